// ---- rtl/ppg_pkg.sv ----
// Purpose: constants and types for the cascaded 16-bit pulse generator
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned registers
// Notes: all offsets are byte addresses
package ppg_pkg;
	localparam logic [7:0] PPG_OFS_CTRL = 8'h00;
	localparam logic [7:0] PPG_OFS_MODE = 8'h04;
	localparam logic [7:0] PPG_OFS_CYC_LO = 8'h08;
	localparam logic [7:0] PPG_OFS_CYC_HI = 8'h0c;
	localparam logic [7:0] PPG_OFS_DUTY_LO = 8'h10;
	localparam logic [7:0] PPG_OFS_DUTY_HI = 8'h14;
	localparam logic [7:0] PPG_OFS_STATUS = 8'h18;
	localparam logic [7:0] PPG_OFS_MASK = 8'h1c;
	localparam logic [7:0] PPG_OFS_COUNT = 8'h20;
	// control register fields
	localparam int PPG_CTRL_CASCADE = 0;
	localparam int PPG_CTRL_RUN = 1;
	// mode register fields
	localparam int PPG_MODE_OPM_LO = 0;
	localparam int PPG_MODE_EXT = 2;
	localparam int PPG_MODE_CKS_LO = 3;
	localparam int PPG_MODE_LVL = 6;
	localparam int PPG_MODE_DBE = 7;
	localparam logic [1:0] PPG_OPM_PPG = 2'h3;
	// status / mask fields
	localparam int PPG_IRQ_DUTY = 0;
	localparam int PPG_IRQ_CYCLE = 1;
	localparam logic [7:0] PPG_MODE_RST = 8'h00;
	localparam logic [1:0] PPG_AXI_OKAY = 2'h0;
	localparam logic [1:0] PPG_AXI_SLVERR = 2'h2;
	typedef struct packed {
		logic [15:0] cycle;
		logic [15:0] duty;
	} ppg_cmp_t;
endpackage

// ---- rtl/ppg_timer.sv ----
// Purpose: cascaded 16-bit programmable pulse generator with AXI4-Lite registers
// Assumes: ref_clk 25 MHz, rstn synchronous active low, ext_clk_in asynchronous
// Notes: internal source is ref_clk divided by 2^(clock_select_field)
// How it works
// RULE_01: cascade bit set uses upper settings only
// RULE_02: mode field 11 selects pulse generator
// RULE_03: external select picks pin, else prescaler
// RULE_04: cycle and duty form 16-bit compare values
// RULE_05: upper duty write commits all four
// RULE_06: software writes other three registers first
// RULE_07: stopped pin shows output level bit
// RULE_08: run bit counts selected source edges
// RULE_09: duty match toggles pin, raises duty irq
// RULE_10: cycle match restores pin, irq, clears count
// RULE_11: run cleared stops, zeroes, restores pin
// RULE_12: external clock slow, both phases two cycles
// RULE_13: buffer enable routes commits through buffer
// RULE_14: running buffered values load at cycle match
// RULE_15: stopped commit loads buffer and active
// RULE_16: unbuffered running commit replaces active now
// RULE_17: passed compares wait for wrap; equal matches
// RULE_18: reads return last written values
// RULE_19: counter wraps from all ones to zero
`timescale 1ns/1ps
module ppg_timer import ppg_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk_in,
	output logic pulse_output_pin,
	output logic irq
);
	logic [7:0] timer_pair_control_r;
	logic [7:0] upper_timer_mode_r;
	logic [7:0] cycle_low_r, cycle_high_r, duty_low_r, duty_high_r;
	ppg_cmp_t buf_r, act_r;
	logic [15:0] count_r;
	logic pin_r;
	logic [1:0] stat_r, mask_r;
	logic [7:0] aw_addr_r;
	logic aw_have_r, w_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic ext_s1_r, ext_s2_r, ext_prev_r;
	logic [7:0] presc_r;
	logic cascade_select, run_control, ppg_mode, src_tick;
	logic duty_match, cycle_match, commit, wr_go;
	logic [2:0] clock_select_field;

	assign cascade_select = timer_pair_control_r[PPG_CTRL_CASCADE];
	assign run_control = timer_pair_control_r[PPG_CTRL_RUN];
	assign clock_select_field = upper_timer_mode_r[PPG_MODE_CKS_LO +: 3];
	// the lower timer's own settings do not exist here: only upper mode is consulted
	assign ppg_mode = cascade_select && // RULE_01
		(upper_timer_mode_r[PPG_MODE_OPM_LO +: 2] == PPG_OPM_PPG); // RULE_02

	// write channel: address and data accepted in either order
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign wr_go = aw_have_r && w_have_r;
	assign s_axi_arready = !s_axi_rvalid;

	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PPG_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r <= PPG_OFS_COUNT && aw_addr_r[1:0] == 2'h0)
					? PPG_AXI_OKAY : PPG_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			timer_pair_control_r <= 8'h00;
			upper_timer_mode_r <= PPG_MODE_RST;
			cycle_low_r <= 8'h00;
			cycle_high_r <= 8'h00;
			duty_low_r <= 8'h00;
			duty_high_r <= 8'h00;
			mask_r <= 2'h0;
		end else if (wr_go) begin
			unique case (aw_addr_r)
				PPG_OFS_CTRL: timer_pair_control_r <= lane0(timer_pair_control_r, w_data_r,
					w_strb_r);
				PPG_OFS_MODE: upper_timer_mode_r <= lane0(upper_timer_mode_r, w_data_r,
					w_strb_r);
				PPG_OFS_CYC_LO: cycle_low_r <= lane0(cycle_low_r, w_data_r, w_strb_r);
				PPG_OFS_CYC_HI: cycle_high_r <= lane0(cycle_high_r, w_data_r, w_strb_r);
				PPG_OFS_DUTY_LO: duty_low_r <= lane0(duty_low_r, w_data_r, w_strb_r);
				PPG_OFS_DUTY_HI: duty_high_r <= lane0(duty_high_r, w_data_r, w_strb_r);
				PPG_OFS_MASK: mask_r <= w_strb_r[0] ? w_data_r[1:0] : mask_r;
				default: ;
			endcase
		end
	end

	// software must have written the three other halves first; hardware trusts it
	assign commit = wr_go && aw_addr_r == PPG_OFS_DUTY_HI && w_strb_r[0]; // RULE_05 RULE_06

	// reads of data registers return the written copies, not the active values
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= PPG_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= PPG_AXI_OKAY;
			unique case (s_axi_araddr)
				PPG_OFS_CTRL: s_axi_rdata <= {24'h0, timer_pair_control_r};
				PPG_OFS_MODE: s_axi_rdata <= {24'h0, upper_timer_mode_r};
				PPG_OFS_CYC_LO: s_axi_rdata <= {24'h0, cycle_low_r}; // RULE_18
				PPG_OFS_CYC_HI: s_axi_rdata <= {24'h0, cycle_high_r}; // RULE_18
				PPG_OFS_DUTY_LO: s_axi_rdata <= {24'h0, duty_low_r}; // RULE_18
				PPG_OFS_DUTY_HI: s_axi_rdata <= {24'h0, duty_high_r}; // RULE_18
				PPG_OFS_STATUS: s_axi_rdata <= {30'h0, stat_r};
				PPG_OFS_MASK: s_axi_rdata <= {30'h0, mask_r};
				PPG_OFS_COUNT: s_axi_rdata <= {16'h0, count_r};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= PPG_AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// external clock: two-flop sync, then rising-edge detect on the second stage
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk_in;
			ext_s2_r <= ext_s1_r;
			ext_prev_r <= ext_s2_r;
		end
	end

	// prescaler free-runs so tick spacing does not depend on when run is set
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			presc_r <= 8'h00;
		else
			presc_r <= presc_r + 8'h01;
	end

	function automatic logic presc_tick(input logic [7:0] p, input logic [2:0] sel);
		logic [7:0] m;
		m = (8'h01 << sel) - 8'h01;
		presc_tick = (p & m) == m;
	endfunction

	// the pin edge must be held two ref_clk periods each way to be seen
	always_comb begin
		if (upper_timer_mode_r[PPG_MODE_EXT])
			src_tick = ext_s2_r && !ext_prev_r; // RULE_03 RULE_12
		else
			src_tick = presc_tick(presc_r, clock_select_field); // RULE_03
	end

	// compares are combinational on the active values, so a commit equal to
	// the current count matches straight after the write unless it is buffered while running
	assign duty_match = ppg_mode && run_control && count_r == act_r.duty; // RULE_04 RULE_17
	assign cycle_match = ppg_mode && run_control && count_r == act_r.cycle; // RULE_04 RULE_17

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			count_r <= 16'h0000;
		end else if (!ppg_mode || !run_control) begin
			count_r <= 16'h0000; // RULE_11
		end else if (src_tick) begin
			if (cycle_match)
				count_r <= 16'h0000; // RULE_10
			else
				count_r <= count_r + 16'h0001; // RULE_08 RULE_19
		end
	end

	// matches act once per count value: only on the tick that leaves that value
	logic duty_ev, cycle_ev;
	assign duty_ev = duty_match && src_tick;
	assign cycle_ev = cycle_match && src_tick;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pin_r <= 1'b0;
		end else if (!ppg_mode || !run_control) begin
			pin_r <= upper_timer_mode_r[PPG_MODE_LVL]; // RULE_07 RULE_11
		end else if (cycle_ev) begin
			pin_r <= upper_timer_mode_r[PPG_MODE_LVL]; // RULE_10
		end else if (duty_ev) begin
			pin_r <= !upper_timer_mode_r[PPG_MODE_LVL]; // RULE_09
		end
	end
	assign pulse_output_pin = pin_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			buf_r <= '0;
			act_r <= '0;
		end else begin
			if (commit)
				buf_r <= {cycle_high_r, cycle_low_r, w_data_r[7:0], duty_low_r}; // RULE_04
			if (commit && (!run_control || !upper_timer_mode_r[PPG_MODE_DBE]))
				act_r <= {cycle_high_r, cycle_low_r, w_data_r[7:0], duty_low_r}; // RULE_15 RULE_16
			else if (cycle_ev && upper_timer_mode_r[PPG_MODE_DBE])
				act_r <= buf_r; // RULE_13 RULE_14
		end
	end

	// sticky status: set wins over write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			stat_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == PPG_IRQ_DUTY && duty_ev) || (i == PPG_IRQ_CYCLE && cycle_ev))
					stat_r[i] <= 1'b1; // RULE_09 RULE_10 RULE_14
				else if (wr_go && aw_addr_r == PPG_OFS_STATUS && w_strb_r[0] && w_data_r[i])
					stat_r[i] <= 1'b0;
			end
		end
	end
	assign irq = |(stat_r & mask_r);
endmodule

// ---- tb/ppg_timer_asserts.sv ----
// Purpose: bus handshake checks on the pulse generator ports
// Assumes: rstn synchronous active low on ref_clk
// Notes: pin timing depends on register state and is judged by the bench
`timescale 1ns/1ps
module ppg_timer_asserts import ppg_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_b_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_ar_held: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	chk_r_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
		|=> s_axi_rresp == PPG_AXI_SLVERR) else $error("unmapped read accepted");
	chk_r_upper: assert property (s_axi_rvalid && s_axi_rresp == PPG_AXI_OKAY |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind ppg_timer ppg_timer_asserts chk_i (.ref_clk(ref_clk), .rstn(rstn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- tb/ppg_load.sv ----
// Purpose: load on the pulse pin that times its levels, plus an external count clock
// Assumes: one ref_clk domain
// Notes: the external clock stands low while not wanted
`timescale 1ns/1ps
module ppg_load (
	input wire logic ref_clk,
	input wire logic pin,
	input wire logic ext_en,
	output logic ext_clk,
	output logic [15:0] hi_t,
	output logic [15:0] per_t
);
	logic [15:0] t_r = 16'h0;
	logic [15:0] rise_r = 16'h0;
	logic last_r = 1'b0;
	logic [1:0] div_r = 2'h0;
	always @(posedge ref_clk) begin
		t_r <= t_r + 16'h1;
		last_r <= pin;
		if (pin && !last_r) begin
			per_t <= t_r - rise_r;
			rise_r <= t_r;
		end
		if (!pin && last_r)
			hi_t <= t_r - rise_r;
		div_r <= ext_en ? div_r + 2'h1 : 2'h0;
		// four cycles a phase keeps both phases long and the rate under half
		ext_clk <= ext_en && (div_r == 2'h3 ? !ext_clk : ext_clk);
	end
endmodule

// ---- tb/ppg_timer_tb.sv ----
// Purpose: self-checking bench for the cascaded pulse generator
// Assumes: the load model times the pin and makes the external clock
// Notes: pulse times follow from the cycle and duty values set
`timescale 1ns/1ps
module ppg_timer_tb import ppg_pkg::*;;
	logic ref_clk, rstn, awv, wv, bq, arv, rq, ext_en, awr, wrd, bv, arr, rv, pin, irq, xck;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0] br, rr;
	logic [15:0] hi_t, per_t;
	int n_mismatch, checks, cyc;
	ppg_timer dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq), .ext_clk_in(xck),
		.pulse_output_pin(pin), .irq(irq));
	ppg_load load (.ref_clk(ref_clk), .pin(pin), .ext_en(ext_en), .ext_clk(xck),
		.hi_t(hi_t), .per_t(per_t));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, e, a);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ap, dp;
		ap = 1'b1;
		dp = 1'b1;
		@(posedge ref_clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bq <= 1'b1;
		// aw and w may be taken at different edges, so each drops on its own ready
		while (ap || dp) begin
			@(posedge ref_clk);
			ap = ap && !awr;
			dp = dp && !wrd;
			awv <= ap;
			wv <= dp;
		end
		while (!bv) @(posedge ref_clk);
		bq <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, br});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk);
		ara <= a;
		arv <= 1'b1;
		rq <= 1'b1;
		do @(posedge ref_clk); while (!arr);
		arv <= 1'b0;
		do @(posedge ref_clk); while (!rv);
		rq <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rr});
		if (er == PPG_AXI_OKAY) chk("rdata", e, rdat);
	endtask
	task automatic setcmp(input logic [15:0] c, input logic [15:0] d);
		wr(PPG_OFS_CYC_LO, {24'h0, c[7:0]});
		wr(PPG_OFS_CYC_HI, {24'h0, c[15:8]});
		wr(PPG_OFS_DUTY_LO, {24'h0, d[7:0]});
		wr(PPG_OFS_DUTY_HI, {24'h0, d[15:8]});
	endtask
	task automatic t_regs();
		rd(PPG_OFS_MODE, {24'h0, PPG_MODE_RST}, PPG_AXI_OKAY);
		setcmp(16'h0009, 16'h0003);
		rd(PPG_OFS_CYC_LO, 32'h9, PPG_AXI_OKAY);
		rd(8'h24, 32'h0, PPG_AXI_SLVERR);
		wr(8'h28, 32'h0, PPG_AXI_SLVERR);
		wr(PPG_OFS_MODE, 32'h3);
		wr(PPG_OFS_CTRL, 32'h2);
		repeat (30) @(posedge ref_clk);
		rd(PPG_OFS_COUNT, 32'h0, PPG_AXI_OKAY);
		wr(PPG_OFS_CTRL, 32'h1);
	endtask
	task automatic t_run(input logic [7:0] m, input logic [15:0] hi, input logic [15:0] per);
		wr(PPG_OFS_MODE, {24'h0, m});
		wr(PPG_OFS_CTRL, 32'h3);
		repeat (400) @(posedge ref_clk);
		chk("high time", {16'h0, hi}, {16'h0, hi_t});
		chk("period", {16'h0, per}, {16'h0, per_t});
		wr(PPG_OFS_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("idle pin", {31'h0, m[6]}, {31'h0, pin});
		rd(PPG_OFS_COUNT, 32'h0, PPG_AXI_OKAY);
	endtask
	task automatic t_irq();
		// the previous scenario left the external source selected with no clock running
		wr(PPG_OFS_MODE, 32'h3);
		wr(PPG_OFS_STATUS, 32'h3);
		wr(PPG_OFS_MASK, 32'h3);
		chk("idle irq", 32'h0, {31'h0, irq});
		wr(PPG_OFS_CTRL, 32'h3);
		repeat (30) @(posedge ref_clk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(PPG_OFS_STATUS, 32'h3, PPG_AXI_OKAY);
		wr(PPG_OFS_MASK, 32'h0);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(PPG_OFS_CTRL, 32'h1);
		wr(PPG_OFS_STATUS, 32'h3);
		rd(PPG_OFS_STATUS, 32'h0, PPG_AXI_OKAY);
	endtask
	task automatic t_cmp();
		for (int b = 0; b < 2; b++) begin
			setcmp(16'h0009, 16'h0003);
			wr(PPG_OFS_MODE, b ? 32'h83 : 32'h03);
			wr(PPG_OFS_CTRL, 32'h3);
			repeat (40) @(posedge ref_clk);
			setcmp(16'h0013, 16'h0005);
			rd(PPG_OFS_DUTY_LO, 32'h5, PPG_AXI_OKAY);
			repeat (100) @(posedge ref_clk);
			chk("new period", 32'h14, {16'h0, per_t});
			chk("new high", 32'he, {16'h0, hi_t});
			wr(PPG_OFS_CTRL, 32'h1);
		end
	endtask
	initial begin
		{rstn, awv, wv, bq, arv, rq, ext_en} = 7'h0;
		{awa, ara, wd} = 48'h0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_run(8'h03, 16'h6, 16'ha);
		t_run(8'h43, 16'h4, 16'ha);
		t_run(8'h0b, 16'hc, 16'h14);
		ext_en <= 1'b1;
		t_run(8'h07, 16'h30, 16'h50);
		ext_en <= 1'b0;
		t_irq();
		t_cmp();
		final_report();
	end
endmodule
